// ### inc/mcs_pkg.sv
// Constants for the metering configuration and sign register group.
// Assumes register indices are word indices on a 32-bit APB bus.
package mcs_pkg;
  // ----------------------------------------------------------------
  // Register indices; the byte address is four times the index.
  // ----------------------------------------------------------------
  localparam int MCS_ADDR_W = 18;
  localparam logic [15:0] IDX_COMP_MODE = 16'he60e;
  localparam logic [15:0] IDX_GAIN = 16'he60f;
  localparam logic [15:0] IDX_FREQ_MODE = 16'he610;
  localparam logic [15:0] IDX_PHCAL_A = 16'he614;
  localparam logic [15:0] IDX_PHCAL_B = 16'he615;
  localparam logic [15:0] IDX_PHCAL_C = 16'he616;
  localparam logic [15:0] IDX_SIGN = 16'he617;
  localparam logic [15:0] IDX_ACC_MODE = 16'he701;
  // ----------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------
  localparam int FLD_W = 3;
  localparam int COMP_ANGLE_LSB = 9;
  localparam int COMP_NOMV_LSB = 11;
  localparam int COMP_FREQ_BIT = 14;
  localparam int FMODE_DIS_LSB = 9;
  localparam int FMODE_CAP_LSB = 12;
  localparam int ACC_ACT_KIND_BIT = 6;
  localparam int ACC_REACT_KIND_BIT = 7;
  localparam int SIGN_ACT_LSB = 0;
  localparam int SIGN_SUM1_BIT = 3;
  localparam int SIGN_REACT_LSB = 4;
  localparam int SIGN_SUM2_BIT = 7;
  localparam int PHCAL_W = 10;
  // ----------------------------------------------------------------
  // Reset values and writable bits.
  // ----------------------------------------------------------------
  localparam logic [15:0] COMP_RST = 16'h01ff;
  localparam logic [15:0] GAIN_RST = 16'h0000;
  localparam logic [15:0] FMODE_RST = 16'h0e88;
  localparam logic [15:0] PHCAL_RST = 16'h0000;
  localparam logic [15:0] ACC_RST = 16'h0000;
  localparam logic [15:0] COMP_WMASK = 16'h7fff;
  localparam logic [15:0] GAIN_WMASK = 16'h01ff;
  localparam logic [15:0] FMODE_WMASK = 16'h7fff;
  localparam logic [15:0] PHCAL_WMASK = 16'h03ff;
  localparam logic [15:0] ACC_WMASK = 16'h00c0;
  // ----------------------------------------------------------------
  // Encodings.
  // ----------------------------------------------------------------
  localparam logic [2:0] GAIN_MAX_CODE = 3'h4;
  localparam logic [2:0] SRC_ACT = 3'h0;
  localparam logic [2:0] SRC_REACT = 3'h1;
  localparam logic [2:0] SRC_APP = 3'h2;
  localparam logic [2:0] SRC_FACT = 3'h3;
  localparam logic [2:0] SRC_FREACT = 3'h4;
  localparam logic [9:0] PHC_CUR_MAX = 10'h17f;
  localparam logic [9:0] PHC_FOLD1_MAX = 10'h1ff;
  localparam logic [9:0] PHC_VOLT_MAX = 10'h23f;
  localparam logic [9:0] PHC_FOLD1_BASE = 10'h100;
  localparam logic [9:0] PHC_FOLD2_BASE = 10'h180;
  typedef enum logic [1:0] {
    ANG_VI = 2'h0,
    ANG_VV = 2'h1,
    ANG_II = 2'h2,
    ANG_OFF = 2'h3
  } mcs_angle_t;
  typedef enum logic {
    APB_IDLE = 1'b0,
    APB_ANSWER = 1'b1
  } mcs_apb_t;
endpackage

// ### hdl/mcs_regs.sv
// Configuration and sign register group of a three-phase metering datapath.
// Assumes an APB master on core_clk and a datapath that strobes new powers.
//
// Behaviour
// - Angle select 00 V-I, 01 V-V, 10 I-I angles; 11 stops angle measurement.
// - Nominal-voltage enable per phase swaps measured rms voltage for nominal value.
// - Gain codes 000..100 give gains 1,2,4,8,16; phase current at bits 2:0.
// - Gain codes 101, 110, 111 act as 000, unity gain.
// - Neutral gain bits 5:3, voltage gain bits 8:6, same coding, reset 000.
// - Source codes 000..100 pick active, reactive, apparent, fund active, fund reactive sums.
// - Source codes 101..111 suppress that output's pulses entirely.
// - Source fields at 2:0, 5:3, 8:6 reset to 000, 001, 010.
// - Disable bits 9..11 reset 1, hold pin inactive, converter keeps running.
// - Capture bits 12..14 latch energy registers on each pulse of that output.
// - Computation-mode bit 8 includes phase C in output 3; resets to 1.
// - Calibration 384..511 acts as 256..383; 576..1023 acts as 384..511.
// - Sign bits 0..2 flag negative active power, total or fundamental by select.
// - Sign bits 4..6 flag negative reactive power, total or fundamental by select.
// - Sign bits 3 and 7 flag negative sums of outputs 1 and 2.
// - Reserved bits do nothing and reset to 0.
// - Three include bits per output pick the phases summed for it.
`timescale 1ns/1ps
module mcs_regs
  import mcs_pkg::*;
#(
  parameter int PW = 24
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [MCS_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic powerStrobe,
  input wire logic [3*PW-1:0] activeTotal,
  input wire logic [3*PW-1:0] activeFund,
  input wire logic [3*PW-1:0] reactiveTotal,
  input wire logic [3*PW-1:0] reactiveFund,
  input wire logic [3*PW-1:0] apparentPower,
  input wire logic [3*PW-1:0] rmsVoltage,
  input wire logic [PW-1:0] nominalVoltageValue,
  input wire logic [2:0] dfcPulse,
  output logic [1:0] angleMeasureSelect,
  output logic angleMeasureOn,
  output logic [2:0] phaseCurrentGain,
  output logic [2:0] neutralCurrentGain,
  output logic [2:0] phaseVoltageGain,
  output logic mainsFreqSelect,
  output logic [3*PW-1:0] apparentVoltage,
  output logic [3*PW+5:0] outSum,
  output logic [2:0] outGenerate,
  output logic [2:0] freqOutput,
  output logic [2:0] energyCapture,
  output logic [3*PHCAL_W-1:0] phaseCompValue
);
  localparam int SW = PW + 2;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  mcs_apb_t apbState_q;
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q, rdataD;
  logic [15:0] computation_mode_q, gain_q, freqMode_q, accMode_q;
  logic [15:0] phCal_q [3];
  logic [7:0] signFlags_q;
  logic hit, wrEn, wrAccept;
  logic [15:0] idx;
  logic signed [SW-1:0] sumD [3];

  assign pready = pready_q;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;
  assign idx = paddr[17:2];
  assign hit = (paddr[1:0] == 2'h0) && (idx == IDX_COMP_MODE || idx == IDX_GAIN ||
    idx == IDX_FREQ_MODE || idx == IDX_PHCAL_A || idx == IDX_PHCAL_B ||
    idx == IDX_PHCAL_C || idx == IDX_SIGN || idx == IDX_ACC_MODE);
  // A write lands only at the edge where the master sees pready high.
  assign wrAccept = psel && penable && pready_q && pwrite;
  assign wrEn = wrAccept && hit;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function automatic logic [2:0] effGain(input logic [2:0] code);
    effGain = (code > GAIN_MAX_CODE) ? 3'h0 : code;
  endfunction

  // Folded ranges keep their low seven bits and move onto a new base.
  function automatic logic [9:0] effPhCal(input logic [9:0] v);
    if (v <= PHC_CUR_MAX || (v > PHC_FOLD1_MAX && v <= PHC_VOLT_MAX)) begin
      effPhCal = v;
    end else if (v <= PHC_FOLD1_MAX) begin
      effPhCal = PHC_FOLD1_BASE + {3'h0, v[6:0]};
    end else begin
      effPhCal = PHC_FOLD2_BASE + {3'h0, v[6:0]};
    end
  endfunction

  function automatic logic signed [PW-1:0] pick(input logic [2:0] code, input int p);
    case (code)
      SRC_ACT: pick = activeTotal[p*PW +: PW];
      SRC_REACT: pick = reactiveTotal[p*PW +: PW];
      SRC_APP: pick = apparentPower[p*PW +: PW];
      SRC_FACT: pick = activeFund[p*PW +: PW];
      SRC_FREACT: pick = reactiveFund[p*PW +: PW];
      default: pick = '0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // APB slave: one wait state, then pready for a single cycle.
  // ----------------------------------------------------------------
  always_comb begin
    rdataD = 32'h0;
    case (idx)
      IDX_COMP_MODE: rdataD[15:0] = computation_mode_q;
      IDX_GAIN: rdataD[15:0] = gain_q;
      IDX_FREQ_MODE: rdataD[15:0] = freqMode_q;
      IDX_PHCAL_A: rdataD[15:0] = phCal_q[0];
      IDX_PHCAL_B: rdataD[15:0] = phCal_q[1];
      IDX_PHCAL_C: rdataD[15:0] = phCal_q[2];
      IDX_SIGN: rdataD[7:0] = signFlags_q;
      IDX_ACC_MODE: rdataD[15:0] = accMode_q;
      default: rdataD = 32'h0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      apbState_q <= APB_IDLE;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      case (apbState_q)
        APB_IDLE: begin
          pready_q <= 1'b0;
          pslverr_q <= 1'b0;
          if (psel && penable) begin
            apbState_q <= APB_ANSWER;
            pready_q <= 1'b1;
            pslverr_q <= !hit;
            prdata_q <= (hit && !pwrite) ? rdataD : 32'h0;
          end
        end
        APB_ANSWER: begin
          apbState_q <= APB_IDLE;
          pready_q <= 1'b0;
          pslverr_q <= 1'b0;
        end
        default: begin
          apbState_q <= APB_IDLE;
          pready_q <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Writable registers; reserved bits are masked so they stay zero.
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      computation_mode_q <= COMP_RST;
      gain_q <= GAIN_RST;
      freqMode_q <= FMODE_RST;
      accMode_q <= ACC_RST;
      phCal_q[0] <= PHCAL_RST;
      phCal_q[1] <= PHCAL_RST;
      phCal_q[2] <= PHCAL_RST;
    end else if (wrEn) begin
      case (idx)
        IDX_COMP_MODE: computation_mode_q <= pwdata[15:0] & COMP_WMASK;
        IDX_GAIN: gain_q <= pwdata[15:0] & GAIN_WMASK;
        IDX_FREQ_MODE: freqMode_q <= pwdata[15:0] & FMODE_WMASK;
        IDX_ACC_MODE: accMode_q <= pwdata[15:0] & ACC_WMASK;
        IDX_PHCAL_A: phCal_q[0] <= pwdata[15:0] & PHCAL_WMASK;
        IDX_PHCAL_B: phCal_q[1] <= pwdata[15:0] & PHCAL_WMASK;
        IDX_PHCAL_C: phCal_q[2] <= pwdata[15:0] & PHCAL_WMASK;
        default: computation_mode_q <= computation_mode_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Output sums over the included phases.
  // ----------------------------------------------------------------
  always_comb begin
    for (int o = 0; o < 3; o++) begin
      sumD[o] = '0;
      for (int p = 0; p < 3; p++) begin
        if (computation_mode_q[o*FLD_W + p]) begin
          sumD[o] = sumD[o] + SW'(pick(freqMode_q[o*FLD_W +: FLD_W], p));
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Decoded controls to the datapath.
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      angleMeasureSelect <= ANG_VI;
      angleMeasureOn <= 1'b1;
      phaseCurrentGain <= 3'h0;
      neutralCurrentGain <= 3'h0;
      phaseVoltageGain <= 3'h0;
      mainsFreqSelect <= 1'b0;
      phaseCompValue <= '0;
    end else begin
      angleMeasureSelect <= computation_mode_q[COMP_ANGLE_LSB +: 2];
      angleMeasureOn <= computation_mode_q[COMP_ANGLE_LSB +: 2] != ANG_OFF;
      phaseCurrentGain <= effGain(gain_q[2:0]);
      neutralCurrentGain <= effGain(gain_q[5:3]);
      phaseVoltageGain <= effGain(gain_q[8:6]);
      mainsFreqSelect <= computation_mode_q[COMP_FREQ_BIT];
      for (int p = 0; p < 3; p++) begin
        phaseCompValue[p*PHCAL_W +: PHCAL_W] <= effPhCal(phCal_q[p][9:0]);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      apparentVoltage <= '0;
    end else begin
      for (int p = 0; p < 3; p++) begin
        apparentVoltage[p*PW +: PW] <= computation_mode_q[COMP_NOMV_LSB + p] ?
          nominalVoltageValue : rmsVoltage[p*PW +: PW];
      end
    end
  end

  // ----------------------------------------------------------------
  // Frequency outputs. The converters run regardless of the disable
  // bits, which gate only the pin; the capture strobe has its own enable.
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      outGenerate <= 3'h0;
      freqOutput <= 3'h0;
      energyCapture <= 3'h0;
    end else begin
      for (int o = 0; o < 3; o++) begin
        outGenerate[o] <= freqMode_q[o*FLD_W +: FLD_W] <= SRC_FREACT;
        freqOutput[o] <= dfcPulse[o] && freqMode_q[o*FLD_W +: FLD_W] <= SRC_FREACT &&
          !freqMode_q[FMODE_DIS_LSB + o];
        energyCapture[o] <= dfcPulse[o] && freqMode_q[o*FLD_W +: FLD_W] <= SRC_FREACT &&
          freqMode_q[FMODE_CAP_LSB + o];
      end
    end
  end

  // ----------------------------------------------------------------
  // Sums and sign flags follow each power update; bus writes never
  // reach the flags.
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      outSum <= '0;
      signFlags_q <= 8'h0;
    end else if (powerStrobe) begin
      for (int p = 0; p < 3; p++) begin
        outSum[p*SW +: SW] <= sumD[p];
        signFlags_q[SIGN_ACT_LSB + p] <= accMode_q[ACC_ACT_KIND_BIT] ?
          activeFund[p*PW + PW-1] : activeTotal[p*PW + PW-1];
        signFlags_q[SIGN_REACT_LSB + p] <= accMode_q[ACC_REACT_KIND_BIT] ?
          reactiveFund[p*PW + PW-1] : reactiveTotal[p*PW + PW-1];
      end
      signFlags_q[SIGN_SUM1_BIT] <= sumD[0][SW-1];
      signFlags_q[SIGN_SUM2_BIT] <= sumD[1][SW-1];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_release;
    reset ##1 !reset;
  endsequence
  sequence s_signWrite;
    wrAccept && idx == IDX_SIGN && !powerStrobe;
  endsequence

  property p_angleOff;
    computation_mode_q[COMP_ANGLE_LSB +: 2] == ANG_OFF |=>
      !angleMeasureOn ##1 (!angleMeasureOn || $past(computation_mode_q[COMP_ANGLE_LSB +: 2]) != ANG_OFF);
  endproperty
  a_angleOff: assert property (p_angleOff) else $error("angle measurement not stopped");

  property p_nominal;
    computation_mode_q[COMP_NOMV_LSB] |=> apparentVoltage[PW-1:0] == $past(nominalVoltageValue);
  endproperty
  a_nominal: assert property (p_nominal) else $error("phase A nominal voltage not used");

  property p_gainLegal;
    gain_q[2:0] <= GAIN_MAX_CODE |=> phaseCurrentGain == $past(gain_q[2:0]);
  endproperty
  a_gainLegal: assert property (p_gainLegal) else $error("current gain code wrong");

  property p_gainReserved;
    gain_q[8:6] > GAIN_MAX_CODE |=> phaseVoltageGain == 3'h0;
  endproperty
  a_gainReserved: assert property (p_gainReserved) else $error("reserved gain not unity");

  property p_resetValues;
    disable iff (1'b0) s_release |-> freqMode_q == FMODE_RST && computation_mode_q == COMP_RST && gain_q == GAIN_RST;
  endproperty
  a_resetValues: assert property (p_resetValues) else $error("register reset value wrong");

  property p_noPulse;
    freqMode_q[2:0] > SRC_FREACT |=> !freqOutput[0] && !energyCapture[0] && !outGenerate[0];
  endproperty
  a_noPulse: assert property (p_noPulse) else $error("pulse on reserved source");

  property p_pinGate;
    dfcPulse[0] && freqMode_q[2:0] <= SRC_FREACT |=> freqOutput[0] == !$past(freqMode_q[FMODE_DIS_LSB]);
  endproperty
  a_pinGate: assert property (p_pinGate) else $error("pin disable gating wrong");

  property p_capture;
    dfcPulse[0] && freqMode_q[2:0] <= SRC_FREACT && freqMode_q[FMODE_CAP_LSB] |=> energyCapture[0];
  endproperty
  a_capture: assert property (p_capture) else $error("energy capture missed");

  property p_phcalFold;
    phCal_q[0][9:0] > PHC_VOLT_MAX |=> phaseCompValue[9:0] == PHC_FOLD2_BASE + {3'h0, $past(phCal_q[0][6:0])};
  endproperty
  a_phcalFold: assert property (p_phcalFold) else $error("calibration fold wrong");

  property p_activeSign;
    powerStrobe && !accMode_q[ACC_ACT_KIND_BIT] |=> signFlags_q[1] == $past(activeTotal[2*PW-1]);
  endproperty
  a_activeSign: assert property (p_activeSign) else $error("active sign flag wrong");

  property p_sumSign;
    powerStrobe |=> signFlags_q[SIGN_SUM2_BIT] == $past(sumD[1][SW-1]) && outSum[SW-1:0] == $past(sumD[0]);
  endproperty
  a_sumSign: assert property (p_sumSign) else $error("sum sign flag wrong");

  property p_signReadOnly;
    s_signWrite |=> signFlags_q == $past(signFlags_q);
  endproperty
  a_signReadOnly: assert property (p_signReadOnly) else $error("sign flags changed by write");

  property p_neutralGain;
    gain_q[5:3] <= GAIN_MAX_CODE |=> neutralCurrentGain == $past(gain_q[5:3]);
  endproperty
  a_neutralGain: assert property (p_neutralGain) else $error("neutral gain code wrong");

  property p_apparentRms;
    !computation_mode_q[COMP_NOMV_LSB + 1] |=> apparentVoltage[2*PW-1:PW] == $past(rmsVoltage[2*PW-1:PW]);
  endproperty
  a_apparentRms: assert property (p_apparentRms) else $error("phase B rms voltage not used");

  property p_pinOff;
    freqMode_q[FMODE_DIS_LSB + 1] |=> !freqOutput[1];
  endproperty
  a_pinOff: assert property (p_pinOff) else $error("disabled output pin pulsed");

  property p_captureOff;
    !freqMode_q[FMODE_CAP_LSB + 1] |=> !energyCapture[1];
  endproperty
  a_captureOff: assert property (p_captureOff) else $error("capture without enable");

  property p_reactiveSign;
    powerStrobe && accMode_q[ACC_REACT_KIND_BIT] |=> signFlags_q[SIGN_REACT_LSB + 2] == $past(reactiveFund[3*PW-1]);
  endproperty
  a_reactiveSign: assert property (p_reactiveSign) else $error("reactive sign flag wrong");

  property p_reservedZero;
    gain_q[15:9] == 7'h0 && !computation_mode_q[15] && !freqMode_q[15];
  endproperty
  a_reservedZero: assert property (p_reservedZero) else $error("reserved bit set");
endmodule

// ### verification/mcs_regs_tb_top.sv
// Self-checking bench for the metering configuration and sign register group.
// Assumes the APB slave answers with one wait state and a datapath width of PW.
`timescale 1ns/1ps
module mcs_regs_tb_top import mcs_pkg::*; ;
  localparam int PW = 8;
  localparam int SW = PW + 2;
  logic core_clk, reset, psel, penable, pwrite, pready, pslverr, powerStrobe;
  logic angleMeasureOn, mainsFreqSelect;
  logic [MCS_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [3*PW-1:0] activeTotal, activeFund, reactiveTotal, reactiveFund, apparentPower, rmsVoltage;
  logic [3*PW-1:0] apparentVoltage;
  logic [PW-1:0] nominalVoltageValue;
  logic [2:0] dfcPulse, phaseCurrentGain, neutralCurrentGain, phaseVoltageGain;
  logic [2:0] outGenerate, freqOutput, energyCapture;
  logic [1:0] angleMeasureSelect;
  logic [3*PW+5:0] outSum;
  logic [3*PHCAL_W-1:0] phaseCompValue;
  int nMismatch = 0;
  int checksDone = 0;

  mcs_regs #(.PW(PW)) i_mcs_regs (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .powerStrobe(powerStrobe), .activeTotal(activeTotal), .activeFund(activeFund),
    .reactiveTotal(reactiveTotal), .reactiveFund(reactiveFund), .apparentPower(apparentPower),
    .rmsVoltage(rmsVoltage), .nominalVoltageValue(nominalVoltageValue), .dfcPulse(dfcPulse),
    .angleMeasureSelect(angleMeasureSelect), .angleMeasureOn(angleMeasureOn),
    .phaseCurrentGain(phaseCurrentGain), .neutralCurrentGain(neutralCurrentGain),
    .phaseVoltageGain(phaseVoltageGain), .mainsFreqSelect(mainsFreqSelect),
    .apparentVoltage(apparentVoltage), .outSum(outSum), .outGenerate(outGenerate),
    .freqOutput(freqOutput), .energyCapture(energyCapture), .phaseCompValue(phaseCompValue));

  // ----------------------------------------------------------------
  // Clock, verdict and watchdog.
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checksDone, nMismatch);
    if (nMismatch == 0 && checksDone > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // The whole sequence needs a few hundred cycles; this leaves ample margin.
  initial begin
    repeat (20000) @(posedge core_clk);
    nMismatch++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Access tasks.
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      nMismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Holds the request until pready is seen high; the wait is bounded.
  task automatic apb(input logic wr, input logic [MCS_ADDR_W-1:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) nMismatch++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, {idx, 2'b00}, d, r, e);
  endtask

  task automatic rd(input logic [15:0] idx, output logic [31:0] r);
    logic e;
    apb(1'b0, {idx, 2'b00}, 32'h0, r, e);
  endtask

  // Decoded outputs follow a write one cycle after its completing edge.
  task automatic settle;
    repeat (2) @(posedge core_clk);
    #1;
  endtask

  task automatic pulse(input logic [2:0] p);
    @(posedge core_clk);
    dfcPulse <= p;
    @(posedge core_clk);
    dfcPulse <= 3'h0;
    #1;
  endtask

  task automatic strobe;
    @(posedge core_clk);
    powerStrobe <= 1'b1;
    @(posedge core_clk);
    powerStrobe <= 1'b0;
    #1;
  endtask

  function automatic logic [9:0] fold(input logic [9:0] v);
    if (v > PHC_VOLT_MAX) return PHC_FOLD2_BASE + {3'h0, v[6:0]};
    if (v > PHC_CUR_MAX && v <= PHC_FOLD1_MAX) return PHC_FOLD1_BASE + {3'h0, v[6:0]};
    return v;
  endfunction

  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial begin
    logic [9:0] calv [9];
    logic [31:0] ok;
    logic e;
    calv = '{10'h000, 10'h17f, 10'h180, 10'h1ff, 10'h200, 10'h23f, 10'h240, 10'h2bc, 10'h3ff};
    reset = 1'b1;
    {psel, penable, pwrite, powerStrobe} = 4'h0;
    paddr = '0;
    pwdata = 32'h0;
    dfcPulse = 3'h0;
    activeTotal = {8'h05, 8'h03, 8'hf0};
    activeFund = {8'h01, 8'h80, 8'h01};
    reactiveTotal = {8'h80, 8'h10, 8'h10};
    reactiveFund = {8'hff, 8'h01, 8'h01};
    apparentPower = {8'h20, 8'h02, 8'h01};
    rmsVoltage = {8'h33, 8'h22, 8'h11};
    nominalVoltageValue = 8'h77;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    settle();
    chk({angleMeasureOn, outGenerate, freqOutput, phaseCurrentGain}, 32'h000003c0);
    rd(IDX_COMP_MODE, rdv); chk(rdv, 32'h000001ff);
    rd(IDX_GAIN, rdv); chk(rdv, 32'h00000000);
    rd(IDX_FREQ_MODE, rdv); chk(rdv, 32'h00000e88);
    rd(IDX_SIGN, rdv); chk(rdv, 32'h00000000);
    apb(1'b0, {IDX_SIGN + 16'h1, 2'b00}, 32'h0, rdv, e); chk({e, rdv[30:0]}, 32'h80000000);
    apb(1'b1, {IDX_GAIN, 2'b01}, 32'h1, rdv, e); chk({31'h0, e}, 32'h1);
    // Angle select codes, including the one that stops measurement.
    for (int i = 0; i < 4; i++) begin
      wr(IDX_COMP_MODE, 32'h01ff | (i << COMP_ANGLE_LSB));
      settle();
      chk({angleMeasureSelect, angleMeasureOn}, {i[1:0], i != 3});
    end
    // Every gain code in all three fields, reserved bits set too.
    for (int i = 0; i < 8; i++) begin
      wr(IDX_GAIN, 32'hfe00 | (i * 32'h49));
      settle();
      ok = (i <= 4) ? i : 0;
      chk({phaseVoltageGain, neutralCurrentGain, phaseCurrentGain}, ok * 32'h49);
      rd(IDX_GAIN, rdv); chk(rdv, i * 32'h49);
    end
    // Output 1 source codes with its pin and capture enabled.
    for (int i = 0; i < 8; i++) begin
      wr(IDX_FREQ_MODE, 32'h1c88 | i);
      settle();
      ok = (i <= 4) ? 1 : 0;
      chk(outGenerate, {2'b11, ok[0]});
      pulse(3'h7);
      chk({freqOutput, energyCapture}, {2'b00, ok[0], 2'b00, ok[0]});
    end
    wr(IDX_FREQ_MODE, 32'h1e88);
    pulse(3'h1);
    chk({freqOutput, energyCapture}, 6'h01);
    wr(IDX_FREQ_MODE, 32'hffff);
    rd(IDX_FREQ_MODE, rdv); chk(rdv, 32'h00007fff);
    wr(IDX_FREQ_MODE, 32'h0e88);
    // Calibration values across both legal ranges and both folded ranges.
    wr(IDX_PHCAL_B, 32'hffff);
    for (int i = 0; i < 9; i++) begin
      wr(IDX_PHCAL_A, 32'hfc00 | calv[i]);
      settle();
      chk(phaseCompValue, {10'h000, 10'h1ff, fold(calv[i])});
      rd(IDX_PHCAL_A, rdv); chk(rdv, {22'h0, calv[i]});
    end
    // Nominal voltage on phase A only, plus the mains frequency bit.
    wr(IDX_COMP_MODE, 32'h49ff);
    settle();
    chk({31'h0, mainsFreqSelect}, 32'h00000001);
    chk({8'h0, apparentVoltage}, 32'h00332277);
    // Sign flags with total, then fundamental, per-phase powers; sums keep the same sources.
    wr(IDX_COMP_MODE, 32'h01ff);
    strobe();
    chk({outSum[2*SW +: SW], outSum[0 +: SW]}, {10'h023, 10'h3f8});
    rd(IDX_SIGN, rdv); chk(rdv, 32'h000000c9);
    wr(IDX_ACC_MODE, 32'h00c0);
    wr(IDX_COMP_MODE, 32'h00ff);
    strobe();
    chk(outSum[2*SW +: SW], 10'h003);
    wr(IDX_SIGN, 32'h0000);
    rd(IDX_SIGN, rdv); chk(rdv, 32'h000000ca);
    // A second reset in mid-run restores the reset values.
    @(posedge core_clk);
    reset <= 1'b1;
    @(posedge core_clk);
    reset <= 1'b0;
    rd(IDX_PHCAL_A, rdv); chk(rdv, 32'h00000000);
    rd(IDX_COMP_MODE, rdv); chk(rdv, 32'h000001ff);
    print_verdict();
  end
endmodule
